/* dv/fsmon_osc_model.sv */
// Behavioural external oscillator that feeds the monitored device clock.
`timescale 1ns/1ns
module fsmon_osc_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic park_level,
  output logic      dev_clk
);
  logic cnt;

  // ------------------------------------------------------------------
  // Oscillator
  // ------------------------------------------------------------------
  // A half period of two system clocks keeps the source below clk/2.
  // A stopped source parks at a level of the bench's choosing, since a
  // dead crystal may stop either high or low.
  initial begin
    dev_clk = 1'b0;
    cnt = 1'b0;
  end
  always @(posedge clk) begin
    if (!run) begin
      dev_clk <= park_level;
      cnt <= 1'b0;
    end else begin
      cnt <= ~cnt;
      if (cnt) dev_clk <= ~dev_clk;
    end
  end
endmodule

/* dv/fsmon_top_checker.sv */
// Concurrent checks on the ports of the fail-safe clock monitor.
`timescale 1ns/1ns
module fsmon_top_checker #(
  parameter int OST_EDGES = fsmon_pkg::OST_EDGES,
  parameter int DIVIDE    = fsmon_pkg::RC_DIVIDE
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       monitor_enable_fuse,
  input wire logic       power_mode_entry,
  input wire logic       osc_fail_flag_clear,
  input wire logic       internal_rc_run,
  input wire logic       clk_sel_internal,
  input wire logic       primary_clock_running,
  input wire logic       fail_safe_active,
  input wire logic       watchdog_reset,
  input wire logic [7:0] periph_irq_flags2
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  // Entry to fail-safe and the single watchdog kick that goes with it.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_detect; $rose(fail_safe_active); endsequence
  sequence s_kick; watchdog_reset ##1 !watchdog_reset; endsequence

  chk_wdog_kick: assert property (s_detect |-> s_kick)
    else $error("no watchdog kick");
  chk_kick_cause: assert property (watchdog_reset |-> s_detect)
    else $error("stray watchdog kick");
  chk_flag_set: assert property (s_detect |-> periph_irq_flags2[7])
    else $error("fail flag not set");
  chk_flag_rsvd: assert property (periph_irq_flags2[6:0] == 7'h00)
    else $error("spare flag bits set");
  chk_sel_fail: assert property (fail_safe_active |-> clk_sel_internal)
    else $error("core not on rc clock");
  chk_status_kept: assert property (s_detect |-> primary_clock_running)
    else $error("running bit changed");
  chk_fuse_off: assert property (!monitor_enable_fuse
    |=> !$rose(fail_safe_active)) else $error("detect with fuse off");
  // A frozen block keeps its old run request, so only enabled cycles count.
  chk_rc_run: assert property (monitor_enable_fuse && clk_en
    |=> internal_rc_run) else $error("rc stopped");
  chk_flag_hold: assert property (periph_irq_flags2[7]
    && !osc_fail_flag_clear |=> periph_irq_flags2[7])
    else $error("fail flag lost");
  chk_safe_hold: assert property (fail_safe_active && !power_mode_entry
    |=> fail_safe_active) else $error("fail-safe dropped");
  chk_pm_exit: assert property (fail_safe_active && power_mode_entry
    |=> !fail_safe_active && !primary_clock_running)
    else $error("no fail-safe exit");
  chk_run_sel: assert property ($rose(primary_clock_running)
    |-> !clk_sel_internal) else $error("primary not selected");
endmodule

bind fsmon_top fsmon_top_checker #(.OST_EDGES(OST_EDGES), .DIVIDE(DIVIDE))
  u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .monitor_enable_fuse(monitor_enable_fuse),
  .power_mode_entry(power_mode_entry),
  .osc_fail_flag_clear(osc_fail_flag_clear),
  .internal_rc_run(internal_rc_run), .clk_sel_internal(clk_sel_internal),
  .primary_clock_running(primary_clock_running),
  .fail_safe_active(fail_safe_active), .watchdog_reset(watchdog_reset),
  .periph_irq_flags2(periph_irq_flags2));

/* dv/tb_fsmon_top.sv */
// Self-checking bench for the fail-safe clock monitor.
`timescale 1ns/1ns
module tb_fsmon_top;
  logic        clk = 1'b0;
  logic        rc = 1'b0;
  logic        rst_n, clk_en, fuse, wd_en, pme, clr, osc_run, park;
  logic        rc_run, sel, run, active, wdr, dev;
  logic [7:0]  flags;
  logic [10:0] q[$];
  logic [10:0] prev = 11'hXXX;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;

  fsmon_top #(.OST_EDGES(4), .DIVIDE(4)) dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .monitor_enable_fuse(fuse),
    .watchdog_enable(wd_en), .dev_clk_in(dev), .internal_rc_osc(rc),
    .power_mode_entry(pme), .osc_fail_flag_clear(clr),
    .internal_rc_run(rc_run), .clk_sel_internal(sel),
    .primary_clock_running(run), .fail_safe_active(active),
    .watchdog_reset(wdr), .periph_irq_flags2(flags));
  fsmon_osc_model osc (.clk(clk), .run(osc_run), .park_level(park),
    .dev_clk(dev));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Status words are {running, rc select, fail-safe, flags}.
  task automatic check(input logic [10:0] exp, input logic [10:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 300 && q.size() > 0; i++) @(posedge clk);
  endtask
  task end_sim();
    if (q.size() != 0) check(q.pop_front(), prev);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The RC source toggles every cycle; a hang is cut short by a ceiling.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    rc <= ~rc;
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // Every change of status must be the oldest one still expected, so a
  // spurious detection shows up as an unexpected change.
  initial begin
    forever begin
      @(negedge clk);
      if ({run, sel, active, flags} !== prev) begin
        prev = {run, sel, active, flags};
        check(q.size() ? q.pop_front() : 11'h7FF, prev);
      end
    end
  end

  // Start-up, failure, clear, power-mode exit, fuse off, mid-run reset.
  initial begin
    void'($urandom(47748));
    {rst_n, fuse, pme, clr, osc_run, park} = 6'h00;
    clk_en = 1'b1;
    // The watchdog enable only keeps the RC alive, so any value will do.
    wd_en = 1'($urandom % 2);
    q.push_back(11'h200);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    fuse <= 1'b1;
    osc_run <= 1'b1;
    q.push_back(11'h400);
    q.push_back(11'h780);
    drain();
    repeat (30) @(posedge clk);
    clr <= 1'b1;
    q.push_back(11'h700);
    @(posedge clk) clr <= 1'b0;
    drain();
    repeat (30) @(posedge clk);
    pme <= 1'b1;
    fuse <= 1'b0;
    wd_en <= 1'($urandom % 2);
    q.push_back(11'h200);
    q.push_back(11'h400);
    @(posedge clk) pme <= 1'b0;
    drain();
    repeat (60) @(posedge clk);
    // A frozen block must not detect, even with the fuse now set.
    fuse <= 1'b1;
    clk_en <= 1'b0;
    repeat (30) @(posedge clk);
    clk_en <= 1'b1;
    q.push_back(11'h780);
    drain();
    park <= 1'($urandom % 2);
    osc_run <= 1'b0;
    rst_n <= 1'b0;
    q.push_back(11'h200);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (80) @(posedge clk);
    end_sim();
  end
endmodule

/* inc/fsmon_pkg.sv */
// Shared constants and types for the fail-safe clock monitor.
package fsmon_pkg;

  // --------------------------------------------------------------------
  // Divider and start-up timing
  // --------------------------------------------------------------------
  localparam int RC_DIVIDE  = 64;    // Sample clock = RC clock / 64.
  localparam int OST_EDGES  = 1024;  // Primary clock edges before ready.

  // --------------------------------------------------------------------
  // Flag register layout and reset values
  // --------------------------------------------------------------------
  localparam int         OSC_FAIL_BIT      = 7;
  localparam logic       OSC_FAIL_RESET    = 1'b0;
  localparam logic       LATCH_RESET       = 1'b0;
  localparam logic       PRIMARY_RUN_RESET = 1'b0;

  // --------------------------------------------------------------------
  // Clock control states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STARTUP,
    ST_MONITOR,
    ST_FAILSAFE
  } fsmon_state_t;

endpackage

/* inc/fsmon_sample_if.sv */
// Link between the top module and the sample clock divider.
`timescale 1ns/1ns
interface fsmon_sample_if;
  logic rc_run;        // Keep the RC oscillator and divider running.
  logic sample_level;  // Divided sample clock level.
  logic sample_rise;   // One-cycle pulse on a sample clock rising edge.
  logic sample_fall;   // One-cycle pulse on a sample clock falling edge.

  modport src (
    input  rc_run,
    output sample_level,
    output sample_rise,
    output sample_fall
  );

  modport dst (
    output rc_run,
    input  sample_level,
    input  sample_rise,
    input  sample_fall
  );
endinterface

/* rtl/fsmon_divider.sv */
// Divides the internal RC oscillator down to the monitor sample clock.
`timescale 1ns/1ns
module fsmon_divider #(
  parameter int DIVIDE = fsmon_pkg::RC_DIVIDE
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  input  wire logic   internal_rc_osc,
  fsmon_sample_if.src smp
);

  localparam int HALF  = DIVIDE / 2;
  localparam int CNT_W = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF - 1);

  logic             rc_prev;
  logic [CNT_W-1:0] count;
  logic             level;
  logic             rise;
  logic             fall;
  logic             next_rc_prev;
  logic [CNT_W-1:0] next_count;
  logic             next_level;
  logic             next_rise;
  logic             next_fall;

  // ------------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------------
  // Count RC rising edges; the level toggles every half period, so a
  // whole sample period is DIVIDE RC cycles.
  always_comb begin
    next_rc_prev = internal_rc_osc;
    next_count   = count;
    next_level   = level;
    next_rise    = 1'b0;
    next_fall    = 1'b0;
    if (smp.rc_run && internal_rc_osc && !rc_prev) begin
      if (count == CNT_LAST) begin
        next_count = '0;
        next_level = !level;
        next_rise  = !level;
        next_fall  = level;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_prev <= 1'b0;
      count   <= '0;
      level   <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end else if (clk_en) begin
      rc_prev <= next_rc_prev;
      count   <= next_count;
      level   <= next_level;
      rise    <= next_rise;
      fall    <= next_fall;
    end
  end

  assign smp.sample_level = level;
  assign smp.sample_rise  = rise;
  assign smp.sample_fall  = fall;

endmodule

/* rtl/fsmon_top.sv */
// Fail-safe clock monitor: failure detection, switchover and recovery.
`timescale 1ns/1ns
module fsmon_top #(
  parameter int OST_EDGES = fsmon_pkg::OST_EDGES,
  parameter int DIVIDE    = fsmon_pkg::RC_DIVIDE
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       monitor_enable_fuse,
  input  wire logic       watchdog_enable,
  input  wire logic       dev_clk_in,
  input  wire logic       internal_rc_osc,
  input  wire logic       power_mode_entry,
  input  wire logic       osc_fail_flag_clear,
  output logic            internal_rc_run,
  output logic            clk_sel_internal,
  output logic            primary_clock_running,
  output logic            fail_safe_active,
  output logic            watchdog_reset,
  output logic [7:0]      periph_irq_flags2
);

  localparam int OST_W = $clog2(OST_EDGES + 1);
  localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_EDGES - 1);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  // The first stage feeds only the second stage.
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ------------------------------------------------------------------
  // Sample clock
  // ------------------------------------------------------------------
  fsmon_sample_if smp ();

  fsmon_divider #(
    .DIVIDE          (DIVIDE)
  ) u_divider (
    .clk             (clk),
    .rst_n           (rst_sync_n),
    .clk_en          (clk_en),
    .internal_rc_osc (internal_rc_osc),
    .smp             (smp)
  );

  // The RC keeps running for the monitor, the backup clock and the
  // watchdog, independent of which of them asked for it.
  assign smp.rc_run = internal_rc_run;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  fsmon_pkg::fsmon_state_t state;
  fsmon_pkg::fsmon_state_t next_state;
  logic             dev_prev;
  logic             monitor_latch;
  logic [OST_W-1:0] ost_count;
  logic             osc_fail_flag;
  logic             next_dev_prev;
  logic             next_monitor_latch;
  logic [OST_W-1:0] next_ost_count;
  logic             next_osc_fail_flag;
  logic             next_internal_rc_run;
  logic             next_clk_sel_internal;
  logic             next_primary_clock_running;
  logic             next_fail_safe_active;
  logic             next_watchdog_reset;
  logic             dev_fall;
  logic             failure;

  // Device clock falling edge, seen on the synchronous input.
  assign dev_fall = dev_prev && !dev_clk_in;

  // A failure counts only while the primary clock is in
  // use and monitored; in start-up or fail-safe the core already runs
  // from the RC, whose own failure cannot be seen.
  assign failure = monitor_enable_fuse
                   && (state == fsmon_pkg::ST_MONITOR)
                   && smp.sample_fall && monitor_latch;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    next_state                 = state;
    next_dev_prev              = dev_clk_in;
    next_monitor_latch         = monitor_latch;
    next_ost_count             = ost_count;
    next_osc_fail_flag         = osc_fail_flag;
    next_primary_clock_running = primary_clock_running;
    next_watchdog_reset        = 1'b0;

    // Set wins when a device edge meets a sample rise, so a live clock
    // keeps the latch set for the failure test at the next sample fall.
    if (dev_fall) begin
      next_monitor_latch = 1'b1;
    end else if (smp.sample_rise) begin
      next_monitor_latch = 1'b0;
    end

    // A new failure beats a software clear in the same cycle.
    if (failure) begin
      next_osc_fail_flag = 1'b1;
    end else if (osc_fail_flag_clear) begin
      next_osc_fail_flag = 1'b0;
    end

    unique case (state)
      fsmon_pkg::ST_STARTUP: begin
        // Count primary edges; with no edges the core stays on the RC
        // and the running bit stays clear indefinitely.
        if (power_mode_entry) begin
          next_ost_count = '0;
        end else if (dev_fall) begin
          if (ost_count == OST_LAST) begin
            next_state                 = fsmon_pkg::ST_MONITOR;
            next_primary_clock_running = 1'b1;
            next_monitor_latch         = 1'b1;
            next_ost_count             = '0;
          end else begin
            next_ost_count = ost_count + OST_W'(1);
          end
        end
      end
      fsmon_pkg::ST_MONITOR: begin
        if (failure) begin
          next_state          = fsmon_pkg::ST_FAILSAFE;
          next_watchdog_reset = 1'b1;
        end
      end
      fsmon_pkg::ST_FAILSAFE: begin
        // Only a power-managed mode entry leaves; the status bit keeps
        // its old value throughout, hiding the substitute source.
        if (power_mode_entry) begin
          next_state                 = fsmon_pkg::ST_STARTUP;
          next_primary_clock_running = fsmon_pkg::PRIMARY_RUN_RESET;
          next_ost_count             = '0;
        end
      end
    endcase

    next_clk_sel_internal = (next_state != fsmon_pkg::ST_MONITOR);
    next_fail_safe_active = (next_state == fsmon_pkg::ST_FAILSAFE);
    next_internal_rc_run  = monitor_enable_fuse
                            || watchdog_enable
                            || next_clk_sel_internal;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Reset puts the core on the RC with the primary clock starting.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state                 <= fsmon_pkg::ST_STARTUP;
      dev_prev              <= 1'b0;
      monitor_latch         <= fsmon_pkg::LATCH_RESET;
      ost_count             <= '0;
      osc_fail_flag         <= fsmon_pkg::OSC_FAIL_RESET;
      internal_rc_run       <= 1'b1;
      clk_sel_internal      <= 1'b1;
      primary_clock_running <= fsmon_pkg::PRIMARY_RUN_RESET;
      fail_safe_active      <= 1'b0;
      watchdog_reset        <= 1'b0;
      periph_irq_flags2     <= 8'h00;
    end else if (clk_en) begin
      state                 <= next_state;
      dev_prev              <= next_dev_prev;
      monitor_latch         <= next_monitor_latch;
      ost_count             <= next_ost_count;
      osc_fail_flag         <= next_osc_fail_flag;
      internal_rc_run       <= next_internal_rc_run;
      clk_sel_internal      <= next_clk_sel_internal;
      primary_clock_running <= next_primary_clock_running;
      fail_safe_active      <= next_fail_safe_active;
      watchdog_reset        <= next_watchdog_reset;
      periph_irq_flags2     <= 8'h00;
      periph_irq_flags2[fsmon_pkg::OSC_FAIL_BIT] <= next_osc_fail_flag;
    end
  end

endmodule
